// File: src/wfe_edge_prog.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
// ****************************************************************
// Waveform edge programming register bank with edge playback
// ****************************************************************

// Overview of operation
// - The sixteen-bit coarse field gives how many whole reference periods are counted before the edge; the timer counts 4 ns clk cycles instead.
// - Once the coarse count ends the edge carries its vernier value to set its final position.
// - The vernier lives in bits 15 to 10 as an unsigned count of 2.5 ns/64 steps.
// - Action codes 0x0 to 0x6 are no action, drive low, drive high, force off, on, down and up.
// - Action codes 0x7 to 0xA strobe an edge compare for low, high, off and valid.
// - On edge two codes 0xB to 0xE open a compare window expecting low, high, high-Z and valid.
// - On edge two code 0xF asks for a compare of unknown value.
// - On edge three there are no window-open codes and 0xF closes a window or compares unknown.
// - Entry accesses use the eight-bit programming address, which auto-increments and reads back.
module wfe_edge_prog (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        wave_start,
   input  wire logic [wfe_pkg::ADDR_W-1:0]  wave_sel,
   output logic [2:0]                       edge_fire,
   output logic [2:0][wfe_pkg::FINE_W-1:0]  edge_fine,
   output logic [2:0][wfe_pkg::ACT_W-1:0]   edge_action,
   output logic                             drive_on,
   output logic                             drive_level,
   output logic                             cmp_strobe,
   output logic [1:0]                       cmp_expect,
   output logic                             window_open,
   output logic [1:0]                       window_expect,
   output logic                             cmp_unknown
);
   import wfe_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [ENTRY_W-1:0]  fine_mem   [NUM_EDGES][ENTRIES];
   logic [COARSE_W-1:0] coarse_mem [NUM_EDGES][ENTRIES];
   logic [CAL_W-1:0]    cal_mem    [ENTRIES];
   logic [ENTRY_W-1:0]  stage_reg  [NUM_EDGES];
   logic [ADDR_W-1:0]   prog_addr_reg;
   logic [5:0]          last_wr_idx_reg;
   logic                last_wr_valid_reg;
   logic [5:0]          idx;
   logic [1:0]          acc_edge;
   logic                setup;
   logic                done_ok;
   logic                wr_done;
   logic                rd_done;
   logic                bad_addr;
   logic [31:0]         rd_word;
   logic [2:0]          tmr_busy;

   // Decode helpers
   function automatic logic is_fine(input logic [5:0] i);
      return i == IDX_E1_FINE || i == IDX_E2_FINE || i == IDX_E3_FINE;
   endfunction

   function automatic logic is_coarse(input logic [5:0] i);
      return i == IDX_E1_COARSE || i == IDX_E2_COARSE || i == IDX_E3_COARSE;
   endfunction

   function automatic logic is_mapped(input logic [5:0] i);
      return is_fine(i) || is_coarse(i) || i == IDX_PROG_ADDR || i == IDX_CAL0;
   endfunction

   // Bus phase decode
   assign idx      = paddr[7:2];
   assign acc_edge = 2'((idx - IDX_E1_FINE) >> 1);
   assign setup    = psel && !penable;
   assign bad_addr = !is_mapped(idx) || paddr[1:0] != 2'h0;
   assign done_ok  = psel && penable && pready && !pslverr;
   assign wr_done  = done_ok && pwrite;
   assign rd_done  = done_ok && !pwrite;

   // ****************************************************************
   // APB slave
   // ****************************************************************

   // Read word for the addressed register
   always_comb begin
      rd_word = '0;
      if (is_fine(idx)) begin
         rd_word[FINE_MSB:FINE_LSB] = fine_mem[acc_edge][prog_addr_reg][ENTRY_W-1:ACT_W];
         rd_word[ACT_MSB:ACT_LSB]   = fine_mem[acc_edge][prog_addr_reg][ACT_W-1:0];
      end else if (is_coarse(idx)) begin
         rd_word[COARSE_W-1:0] = coarse_mem[acc_edge][prog_addr_reg];
      end else if (idx == IDX_CAL0) begin
         rd_word[CAL_W-1:0] = cal_mem[prog_addr_reg];
      end else if (idx == IDX_PROG_ADDR) begin
         rd_word[ADDR_W-1:0] = prog_addr_reg;
      end
   end

   // No wait state: answer prepared in setup, taken at first access edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && bad_addr;
         if (setup) begin
            prdata <= (pwrite || bad_addr) ? 32'h0000_0000 : rd_word;
         end
      end
   end

   // Programming address, loaded, or stepped after any read or write of edge three coarse or calibration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_addr_reg <= PROG_ADDR_RST;
      end else if (wr_done && idx == IDX_PROG_ADDR) begin
         prog_addr_reg <= pwdata[ADDR_W-1:0];
      end else if ((wr_done || rd_done) && (idx == IDX_E3_COARSE || idx == IDX_CAL0)) begin
         prog_addr_reg <= prog_addr_reg + 8'h01;
      end
   end

   // Last register written, to pair vernier with coarse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_wr_idx_reg   <= '0;
         last_wr_valid_reg <= 1'b0;
      end else if (wr_done) begin
         last_wr_idx_reg   <= idx;
         last_wr_valid_reg <= 1'b1;
      end
   end

   // Vernier/action held until its coarse write commits the entry
   always_ff @(posedge clk) begin
      if (wr_done && is_fine(idx)) begin
         stage_reg[acc_edge] <= {pwdata[FINE_MSB:FINE_LSB], pwdata[ACT_MSB:ACT_LSB]};
      end
   end

   // Memory writes, left unreset
   always_ff @(posedge clk) begin
      if (wr_done && is_coarse(idx)) begin
         coarse_mem[acc_edge][prog_addr_reg] <= pwdata[COARSE_W-1:0];
         if (last_wr_valid_reg && last_wr_idx_reg == idx - 6'h01) begin
            fine_mem[acc_edge][prog_addr_reg] <= stage_reg[acc_edge];
         end
      end
      if (wr_done && idx == IDX_CAL0) begin
         cal_mem[prog_addr_reg] <= pwdata[CAL_W-1:0];
      end
   end

   // ****************************************************************
   // Edge playback
   // ****************************************************************

   // One coarse timer per edge
   generate
      for (genvar e = 0; e < NUM_EDGES; e++) begin : g_edge
         wfe_edge_timer wfe_edge_timer_inst (
            .clk         (clk),
            .rst_n       (rst_n),
            .launch      (wave_start),
            .coarse_in   (coarse_mem[e][wave_sel]),
            .fine_in     (fine_mem[e][wave_sel][ENTRY_W-1:ACT_W]),
            .action_in   (fine_mem[e][wave_sel][ACT_W-1:0]),
            .busy        (tmr_busy[e]),
            .fire        (edge_fire[e]),
            .fire_fine   (edge_fine[e]),
            .fire_action (edge_action[e])
         );
      end
   endgenerate

   // Drive state; a later edge wins when two fire together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_on    <= 1'b0;
         drive_level <= 1'b0;
      end else begin
         for (int e = 0; e < NUM_EDGES; e++) begin
            if (edge_fire[e]) begin
               unique case (edge_action[e])
                  ACT_DRV_LOW: begin
                     drive_on    <= 1'b1;
                     drive_level <= 1'b0;
                  end
                  ACT_DRV_HIGH: begin
                     drive_on    <= 1'b1;
                     drive_level <= 1'b1;
                  end
                  ACT_FRC_OFF:  drive_on    <= 1'b0;
                  ACT_FRC_ON:   drive_on    <= 1'b1;
                  ACT_FRC_DOWN: drive_level <= 1'b0;
                  ACT_FRC_UP:   drive_level <= 1'b1;
                  default: ;
               endcase
            end
         end
      end
   end

   // Edge compare strobe with expected level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_strobe <= 1'b0;
         cmp_expect <= '0;
      end else begin
         cmp_strobe <= 1'b0;
         for (int e = 0; e < NUM_EDGES; e++) begin
            if (edge_fire[e] && wfe_classify(2'(e), edge_action[e]) == CLS_EDGE_CMP) begin
               cmp_strobe <= 1'b1;
               cmp_expect <= 2'(edge_action[e] - ACT_CMP_LOW);
            end
         end
      end
   end

   // Compare window and unknown compare; an open beats a close
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         window_open   <= 1'b0;
         window_expect <= '0;
         cmp_unknown   <= 1'b0;
      end else begin
         cmp_unknown <= 1'b0;
         if (edge_fire[EDGE_TWO] && wfe_classify(EDGE_TWO, edge_action[EDGE_TWO]) == CLS_WIN_OPEN) begin
            window_open   <= 1'b1;
            window_expect <= 2'(edge_action[EDGE_TWO] - ACT_WIN_LOW);
         end else if (edge_fire[EDGE_THREE] && edge_action[EDGE_THREE] == ACT_UNKNOWN && window_open) begin
            window_open <= 1'b0;
         end
         if (edge_fire[EDGE_TWO] && wfe_classify(EDGE_TWO, edge_action[EDGE_TWO]) == CLS_UNKNOWN) begin
            cmp_unknown <= 1'b1;
         end
         if (edge_fire[EDGE_THREE] && edge_action[EDGE_THREE] == ACT_UNKNOWN && !window_open) begin
            cmp_unknown <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************

   chk_fine_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      (setup && !pwrite && is_fine(idx) && !bad_addr)
      |=> prdata[FINE_MSB:FINE_LSB] == $past(fine_mem[acc_edge][prog_addr_reg][ENTRY_W-1:ACT_W]))
      else $error("vernier field read back wrong");

   chk_unused_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      (psel && penable && pready && !pwrite && is_fine(idx)) |-> prdata[9:4] == 6'h00 && prdata[31:16] == 16'h0000)
      else $error("unused vernier bits not zero");

   chk_addr_step: assert property (
      @(posedge clk) disable iff (!rst_n)
      (done_ok && idx == IDX_E3_COARSE) |=> prog_addr_reg == $past(prog_addr_reg) + 8'h01)
      else $error("programming address did not step");

   chk_addr_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      (setup && !pwrite && idx == IDX_PROG_ADDR && paddr[1:0] == 2'h0)
      |=> pready && prdata == {24'h000000, $past(prog_addr_reg)})
      else $error("programming address read back wrong");

   chk_drive_high: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b010 && edge_action[EDGE_TWO] == ACT_DRV_HIGH) |=> drive_on && drive_level)
      else $error("drive high not applied");

   chk_edge_compare: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b010 && edge_action[EDGE_TWO] == 4'h8) |=> cmp_strobe && cmp_expect == 2'h1 ##1 !cmp_strobe)
      else $error("edge compare high not strobed once");

   chk_window_opens: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire[EDGE_TWO] && edge_action[EDGE_TWO] == 4'hD) |=> window_open && window_expect == 2'h2)
      else $error("edge two did not open high-Z window");

   chk_unknown_two: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire[EDGE_TWO] && edge_action[EDGE_TWO] == ACT_UNKNOWN) |=> cmp_unknown)
      else $error("edge two unknown compare missing");

   chk_three_closes: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b100 && edge_action[EDGE_THREE] == ACT_UNKNOWN && window_open) |=> !window_open && !cmp_unknown)
      else $error("edge three did not close window");

   chk_three_no_open: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b100 && !window_open) |=> !window_open)
      else $error("edge three opened a window");

   chk_ready_single: assert property (
      @(posedge clk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready too long");

   chk_refused_keeps: assert property (
      @(posedge clk) disable iff (!rst_n)
      (pready && pslverr) |=> prog_addr_reg == $past(prog_addr_reg))
      else $error("refused moved address");

   chk_addr_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_done && idx == IDX_PROG_ADDR) |=> prog_addr_reg == $past(pwdata[ADDR_W-1:0]))
      else $error("address not loaded");

   chk_coarse_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      (setup && !pwrite && is_coarse(idx) && !bad_addr)
      |=> prdata == {16'h0000, $past(coarse_mem[acc_edge][prog_addr_reg])})
      else $error("coarse read wrong");

   chk_drive_low: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b010 && edge_action[EDGE_TWO] == ACT_DRV_LOW) |=> drive_on && !drive_level)
      else $error("drive low missing");

   chk_force_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b010 && edge_action[EDGE_TWO] == ACT_FRC_OFF) |=> !drive_on)
      else $error("force off missing");

   chk_three_unknown: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire == 3'b100 && edge_action[EDGE_THREE] == ACT_UNKNOWN && !window_open) |=> cmp_unknown)
      else $error("edge three unknown missing");

   chk_fire_idle: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edge_fire & tmr_busy) == 3'b000)
      else $error("edge fired while counting");

endmodule

// File: common/wfe_pkg.sv
// ****************************************************************
// Waveform edge programming constants
// ****************************************************************
package wfe_pkg;

   // Timing figures
   localparam int REF_PERIOD_PS  = 2500;
   localparam int VERN_STEPS     = 64;
   localparam int VERN_STEP_FS   = REF_PERIOD_PS * 1000 / VERN_STEPS;
   localparam int CLK_PERIOD_PS  = 4000;

   // Field widths and positions
   localparam int COARSE_W  = 16;
   localparam int FINE_W    = 6;
   localparam int ACT_W     = 4;
   localparam int ENTRY_W   = FINE_W + ACT_W;
   localparam int ADDR_W    = 8;
   localparam int ENTRIES   = 256;
   localparam int NUM_EDGES = 3;
   localparam int CAL_W     = 8;
   localparam int FINE_LSB  = 10;
   localparam int FINE_MSB  = 15;
   localparam int ACT_LSB   = 0;
   localparam int ACT_MSB   = 3;
   localparam int UNUSED_W  = 6;

   // Register indices, byte address is four times the index
   localparam logic [5:0] IDX_PROG_ADDR = 6'h05;
   localparam logic [5:0] IDX_E1_FINE   = 6'h08;
   localparam logic [5:0] IDX_E1_COARSE = 6'h09;
   localparam logic [5:0] IDX_E2_FINE   = 6'h0A;
   localparam logic [5:0] IDX_E2_COARSE = 6'h0B;
   localparam logic [5:0] IDX_E3_FINE   = 6'h0C;
   localparam logic [5:0] IDX_E3_COARSE = 6'h0D;
   localparam logic [5:0] IDX_CAL0      = 6'h0E;

   // Values after reset
   localparam logic [7:0] PROG_ADDR_RST = 8'h00;

   // Action codes
   localparam logic [3:0] ACT_NONE      = 4'h0;
   localparam logic [3:0] ACT_DRV_LOW   = 4'h1;
   localparam logic [3:0] ACT_DRV_HIGH  = 4'h2;
   localparam logic [3:0] ACT_FRC_OFF   = 4'h3;
   localparam logic [3:0] ACT_FRC_ON    = 4'h4;
   localparam logic [3:0] ACT_FRC_DOWN  = 4'h5;
   localparam logic [3:0] ACT_FRC_UP    = 4'h6;
   localparam logic [3:0] ACT_CMP_LOW   = 4'h7;
   localparam logic [3:0] ACT_CMP_VALID = 4'hA;
   localparam logic [3:0] ACT_WIN_LOW   = 4'hB;
   localparam logic [3:0] ACT_WIN_VALID = 4'hE;
   localparam logic [3:0] ACT_UNKNOWN   = 4'hF;

   // Edge numbers inside the design
   localparam logic [1:0] EDGE_ONE   = 2'h0;
   localparam logic [1:0] EDGE_TWO   = 2'h1;
   localparam logic [1:0] EDGE_THREE = 2'h2;

   typedef enum logic [2:0] {
      CLS_NONE, CLS_DRIVE, CLS_EDGE_CMP, CLS_WIN_OPEN, CLS_UNKNOWN, CLS_WIN_CLOSE
   } wfe_class_e;

   // Action class of a code on a given edge
   function automatic wfe_class_e wfe_classify(input logic [1:0] edge_no, input logic [3:0] code);
      wfe_class_e cls;
      cls = CLS_NONE;
      if (code >= ACT_DRV_LOW && code <= ACT_FRC_UP) cls = CLS_DRIVE;
      else if (code >= ACT_CMP_LOW && code <= ACT_CMP_VALID) cls = CLS_EDGE_CMP;
      else if (code >= ACT_WIN_LOW && code <= ACT_WIN_VALID) cls = (edge_no == EDGE_TWO) ? CLS_WIN_OPEN : CLS_NONE;
      else if (code == ACT_UNKNOWN) cls = (edge_no == EDGE_THREE) ? CLS_WIN_CLOSE : CLS_UNKNOWN;
      return cls;
   endfunction

endpackage

// File: src/wfe_edge_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// Single edge coarse counter
// ****************************************************************
module wfe_edge_timer (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         launch,
   input  wire logic [wfe_pkg::COARSE_W-1:0] coarse_in,
   input  wire logic [wfe_pkg::FINE_W-1:0]   fine_in,
   input  wire logic [wfe_pkg::ACT_W-1:0]    action_in,
   output logic                              busy,
   output logic                              fire,
   output logic [wfe_pkg::FINE_W-1:0]        fire_fine,
   output logic [wfe_pkg::ACT_W-1:0]         fire_action
);
   import wfe_pkg::*;

   logic [COARSE_W-1:0] count_reg;
   logic [COARSE_W:0]   elapsed_reg;
   logic [COARSE_W-1:0] coarse_seen_reg;

   // Coarse countdown, edge placed when it reaches zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy      <= 1'b0;
         fire      <= 1'b0;
         count_reg <= '0;
      end else begin
         fire <= 1'b0;
         if (launch && !busy) begin
            busy      <= (coarse_in != '0);
            fire      <= (coarse_in == '0);
            count_reg <= coarse_in - 16'h0001;
         end else if (busy) begin
            if (count_reg == '0) begin
               busy <= 1'b0;
               fire <= 1'b1;
            end
            count_reg <= count_reg - 16'h0001;
         end
      end
   end

   // Fine and action ride along to the edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fire_fine   <= '0;
         fire_action <= '0;
      end else if (launch && !busy) begin
         fire_fine   <= fine_in;
         fire_action <= action_in;
      end
   end

   // Cycles since launch, for checking only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_reg     <= '0;
         coarse_seen_reg <= '0;
      end else if (launch && !busy) begin
         elapsed_reg     <= 17'h00001;
         coarse_seen_reg <= coarse_in;
      end else if (busy) begin
         elapsed_reg <= elapsed_reg + 17'h00001;
      end
   end

   chk_coarse_wait_len: assert property (
      @(posedge clk) disable iff (!rst_n)
      fire |-> elapsed_reg == {1'b0, coarse_seen_reg} + 17'h00001)
      else $error("edge placed after wrong coarse count");

   chk_fine_added: assert property (
      @(posedge clk) disable iff (!rst_n)
      (launch && !busy && coarse_in == '0) |=> fire && fire_fine == $past(fine_in))
      else $error("vernier not carried to edge");

endmodule

// File: tb/tb_waveform_edge_programming.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench for the edge programming bank
// ****************************************************************
module tb_waveform_edge_programming;
   import wfe_pkg::*;
   logic                   clk;
   logic                   rst_n;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   wave_start;
   logic [7:0]             wave_sel;
   logic [2:0]             edge_fire;
   logic [2:0][FINE_W-1:0] edge_fine;
   logic [2:0][ACT_W-1:0]  edge_action;
   logic                   drive_on;
   logic                   drive_level;
   logic                   cmp_strobe;
   logic [1:0]             cmp_expect;
   logic                   window_open;
   logic [1:0]             window_expect;
   logic                   cmp_unknown;
   logic [31:0]            rd;
   logic                   err;
   logic                   exp_on;
   logic                   exp_lvl;
   int                     n_errors;
   int                     checks;

   wfe_edge_prog wfe_edge_prog_inst (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wave_start(wave_start), .wave_sel(wave_sel), .edge_fire(edge_fire),
      .edge_fine(edge_fine), .edge_action(edge_action), .drive_on(drive_on),
      .drive_level(drive_level), .cmp_strobe(cmp_strobe), .cmp_expect(cmp_expect),
      .window_open(window_open), .window_expect(window_expect), .cmp_unknown(cmp_unknown)
   );

   // 250 MHz clock
   always #2 clk = ~clk;

   // ****************************************************************
   // Shared helpers
   // ****************************************************************
   task automatic summarize();
      $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         n_errors++;
         summarize();
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      apb(1'b1, {idx, 2'b00}, {16'h0000, d});
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input string msg);
      apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
      chk({err, rd}, {1'b0, exp}, msg);
   endtask

   function automatic logic [15:0] fw(input logic [5:0] v, input logic [3:0] a);
      return {v, 6'h3F, a};
   endfunction

   // Program one entry, each vernier write right before its coarse write
   task automatic entry(input logic [7:0] s, input logic [15:0] f1, c1, f2, c2, f3, c3);
      wr(IDX_PROG_ADDR, {8'h00, s});
      wr(IDX_E1_FINE, f1);
      wr(IDX_E1_COARSE, c1);
      wr(IDX_E2_FINE, f2);
      wr(IDX_E2_COARSE, c2);
      wr(IDX_E3_FINE, f3);
      wr(IDX_E3_COARSE, c3);
   endtask

   // Launch an entry, time one edge, return in the cycle after its fire
   task automatic play(input logic [7:0] s, input int e, input int c, input logic [15:0] f);
      int i;
      @(posedge clk);
      wave_start <= 1'b1;
      wave_sel <= s;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         wave_start <= 1'b0;
         #1;
         if (edge_fire[e] === 1'b1) break;
      end
      chk(i, c, "fire cycle");
      chk({edge_fine[e], edge_action[e]}, {f[15:10], f[3:0]}, "fine and action");
      if (i == 40) summarize();
      @(posedge clk);
      #1;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_prog();
      entry(8'hFF, 16'hABF7, 16'h0002, fw(6'h15, ACT_WIN_LOW), 16'h0005, fw(6'h3F, ACT_UNKNOWN), 16'h0000);
      rdc(IDX_PROG_ADDR, 32'h0, "address wrap");
      wr(IDX_PROG_ADDR, 16'h00FF);
      rdc(IDX_E1_FINE, 32'hA807, "unused bits");
      rdc(IDX_E1_COARSE, 32'h2, "coarse one");
      rdc(IDX_E2_FINE, 32'h540B, "fine two");
      rdc(IDX_E2_COARSE, 32'h5, "coarse two");
      rdc(IDX_E3_FINE, 32'hFC0F, "fine three");
      rdc(IDX_E3_COARSE, 32'h0, "coarse three");
      rdc(IDX_PROG_ADDR, 32'h0, "read increments");
      play(8'hFF, 1, 5, fw(6'h15, ACT_WIN_LOW));
      play(8'hFF, 0, 2, 16'hABF7);
      play(8'hFF, 2, 0, fw(6'h3F, ACT_UNKNOWN));
      $display("test prog done");
   endtask

   task automatic t_pair();
      wr(IDX_PROG_ADDR, 16'h0010);
      wr(IDX_E1_FINE, fw(6'h01, ACT_DRV_LOW));
      wr(IDX_E1_COARSE, 16'h0003);
      wr(IDX_E1_FINE, fw(6'h3E, ACT_DRV_HIGH));
      wr(IDX_E2_FINE, fw(6'h11, ACT_FRC_OFF));
      wr(IDX_E1_COARSE, 16'hA5C3);
      rdc(IDX_PROG_ADDR, 32'h10, "no increment");
      rdc(IDX_E1_FINE, 32'h0401, "broken pair keeps fine");
      rdc(IDX_E1_COARSE, 32'hA5C3, "coarse full width");
      $display("test pair done");
   endtask

   task automatic t_codes();
      logic [3:0] k;
      for (int j = 0; j < 16; j++) begin
         k = j[3:0];
         entry(8'h20 + 8'(j), fw(6'h00, ACT_NONE), 16'h0, fw(6'(j), k), 16'h0001, fw(6'h00, ACT_NONE), 16'h0);
         play(8'h20 + 8'(j), 1, 1, fw(6'(j), k));
         if (k == 4'h1 || k == 4'h2 || k == 4'h4) exp_on = 1'b1;
         if (k == 4'h3) exp_on = 1'b0;
         if (k == 4'h1 || k == 4'h5) exp_lvl = 1'b0;
         if (k == 4'h2 || k == 4'h6) exp_lvl = 1'b1;
         chk({drive_on, drive_level}, {exp_on, exp_lvl}, "drive state");
         chk(cmp_strobe, k >= 4'h7 && k <= 4'hA, "compare strobe");
         if (k >= 4'h7 && k <= 4'hA) chk(cmp_expect, k - 4'h7, "compare level");
         if (k >= 4'hB && k <= 4'hE) chk({window_open, window_expect}, {1'b1, 2'(k - 4'hB)}, "window");
         chk(cmp_unknown, k == 4'hF, "unknown compare");
      end
      $display("test codes done");
   endtask

   task automatic t_close();
      entry(8'h40, fw(6'h00, ACT_NONE), 16'h0, fw(6'h00, ACT_NONE), 16'h0, fw(6'h05, ACT_UNKNOWN), 16'h0003);
      play(8'h40, 2, 3, fw(6'h05, ACT_UNKNOWN));
      chk({window_open, cmp_unknown}, 2'b00, "window closes");
      play(8'h40, 2, 3, fw(6'h05, ACT_UNKNOWN));
      chk({window_open, cmp_unknown}, 2'b01, "unknown when closed");
      entry(8'h41, fw(6'h00, ACT_NONE), 16'h0, fw(6'h00, ACT_NONE), 16'h0, fw(6'h00, ACT_WIN_LOW), 16'h0);
      play(8'h41, 2, 0, fw(6'h00, ACT_WIN_LOW));
      chk(window_open, 1'b0, "no open on edge three");
      $display("test close done");
   endtask

   task automatic t_misc();
      wr(IDX_PROG_ADDR, 16'h0009);
      wr(IDX_CAL0, 16'h01A5);
      rdc(IDX_PROG_ADDR, 32'h0A, "calibration increments");
      wr(IDX_PROG_ADDR, 16'h0009);
      rdc(IDX_CAL0, 32'hA5, "calibration readback");
      apb(1'b0, 8'hFC, 32'h0);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
      apb(1'b1, 8'h15, 32'h77);
      chk(err, 1'b1, "unaligned write");
      rdc(IDX_PROG_ADDR, 32'h0A, "refused leaves address");
      $display("test misc done");
   endtask

   // Main sequence
   initial begin
      n_errors = 0;
      checks = 0;
      clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wave_start = 1'b0;
      wave_sel = 8'h00;
      exp_on = 1'b0;
      exp_lvl = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({edge_fire, drive_on, window_open, cmp_strobe, cmp_unknown}, 7'h00, "outputs in reset");
      @(posedge clk);
      rst_n <= 1'b1;
      rdc(IDX_PROG_ADDR, {24'h0, PROG_ADDR_RST}, "address after reset");
      t_prog();
      t_pair();
      t_codes();
      t_close();
      t_misc();
      summarize();
   end
endmodule
